// File: logic/clk_delay_defs.svh
// Offsets, field positions, reset values and limits of the delay bank
// Assumes inclusion by bare name from the modules
//
// What this block does
// - A 4-bit read-only field reports the divider phase, in half cycles, held when the sync pulse was captured.
// - That phase field only carries meaning while the divider alignment enable input is high.
// - With alignment on and both skew windows zero, the phase field equals the low nibble of the phase offset input.
// - A 3-bit read-write delay mode field resets to zero, and zero means no delay.
// - Mode 2 applies fine delay limited to 0 to 16 steps.
// - Modes 3 and 4 apply low-jitter fine delay limited to 0 to 16 steps.
// - Mode 6 allows fine delay up to 192 steps and super fine delay up to 128 steps.
// - An 8-bit super fine setting counts 0.25 ps steps from 0 up to 128.
// - The super fine setting applies only in modes 2 and 6.
// - An 8-bit fine setting counts 1.725 ps steps and resets to 192.
// - The fine setting applies only in modes 2, 3, 4 and 6.
`ifndef CLK_DELAY_DEFS_SVH
`define CLK_DELAY_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_PHASE_STATUS   12'h010B
`define OFS_DELAY_MODE     12'h0110
`define OFS_SUPER_FINE     12'h0111
`define OFS_FINE           12'h0112

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define PHASE_MSB          3
`define MODE_MSB           2
`define RST_MODE           3'h0
`define RST_SUPER_FINE     8'h00
`define RST_FINE           8'hC0

// ----------------------------------------
// Range limits in steps
// ----------------------------------------
`define FINE_MAX_SHORT     8'h10
`define FINE_MAX_FULL      8'hC0
`define SUPER_FINE_MAX     8'h80

`endif

// File: logic/clk_delay_pkg.sv
// Types shared by the delay register bank
// Assumes the defs header is on the include path
package clk_delay_pkg;
    typedef enum logic [2:0] {
        MODE_OFF      = 3'h0,
        MODE_FINE     = 3'h2,
        MODE_FINE_LJ  = 3'h3,
        MODE_FINE_LJ2 = 3'h4,
        MODE_FULL     = 3'h6
    } delay_mode_type;

    typedef struct packed {
        logic       fine_en;
        logic       low_jitter;
        logic       super_fine_en;
        logic [7:0] fine_steps;
        logic [7:0] super_fine_steps;
    } delay_ctrl_type;
endpackage

// File: logic/delay_limit.sv
// Turns mode and stored settings into applied, clamped delay controls
// Assumes settings come straight from the register flops
module delay_limit
    import clk_delay_pkg::*;
(
    // Inputs
    input  wire logic [2:0]     mode_i,
    input  wire logic [7:0]     fine_i,
    input  wire logic [7:0]     super_fine_i,
    // Applied control
    output delay_ctrl_type      ctrl_o
);
`include "clk_delay_defs.svh"

    logic [7:0] fine_lim;

    always_comb begin
        ctrl_o   = '0;
        fine_lim = `FINE_MAX_FULL;
        case (mode_i)
            MODE_FINE: begin
                ctrl_o.fine_en       = 1'b1;
                ctrl_o.super_fine_en = 1'b1;
                fine_lim             = `FINE_MAX_SHORT;
            end
            MODE_FINE_LJ, MODE_FINE_LJ2: begin
                ctrl_o.fine_en    = 1'b1;
                ctrl_o.low_jitter = 1'b1;
                fine_lim          = `FINE_MAX_SHORT;
            end
            MODE_FULL: begin
                ctrl_o.fine_en       = 1'b1;
                ctrl_o.super_fine_en = 1'b1;
            end
            default: begin
                fine_lim = `FINE_MAX_FULL;
            end
        endcase
        // Clamp only the applied value, never the stored one
        if (ctrl_o.fine_en) begin
            ctrl_o.fine_steps = (fine_i > fine_lim) ? fine_lim
                                                    : fine_i;
        end
        if (ctrl_o.super_fine_en) begin
            ctrl_o.super_fine_steps = (super_fine_i > `SUPER_FINE_MAX)
                ? `SUPER_FINE_MAX : super_fine_i;
        end
    end
endmodule

// File: logic/sample_clock_delay_regs.sv
// Register bank for sample clock delay and divider phase status
// Assumes phase inputs are synchronous to sys_clk_i; align and skew
// controls come from the neighbouring sync control register
//
// The plain strobed port was decided locally.
module sample_clock_delay_regs
    import clk_delay_pkg::*;
(
    // Clock and reset
    input  wire logic           sys_clk_i,
    input  wire logic           rst_i,
    // Register port
    input  wire logic [11:0]    reg_addr_i,
    input  wire logic [7:0]     reg_wdata_i,
    input  wire logic           reg_wr_i,
    input  wire logic           reg_rd_i,
    output logic [7:0]          reg_rdata_o,
    // Divider phase sources
    input  wire logic           align_en_i,
    input  wire logic [1:0]     neg_skew_i,
    input  wire logic [1:0]     pos_skew_i,
    input  wire logic [3:0]     captured_phase_i,
    input  wire logic [3:0]     phase_offset_i,
    // Applied delay control
    output delay_ctrl_type      delay_ctrl_o
);
`include "clk_delay_defs.svh"

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [2:0]     mode_r;
    logic [7:0]     super_fine_r;
    logic [7:0]     fine_r;
    logic [3:0]     phase_r;
    logic [3:0]     phase_nxt;
    logic [7:0]     rdata_nxt;
    delay_ctrl_type ctrl_nxt;

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mode_r <= `RST_MODE;
        end else if (reg_wr_i && reg_addr_i == `OFS_DELAY_MODE) begin
            mode_r <= reg_wdata_i[`MODE_MSB:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            super_fine_r <= `RST_SUPER_FINE;
        end else if (reg_wr_i && reg_addr_i == `OFS_SUPER_FINE) begin
            super_fine_r <= reg_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            fine_r <= `RST_FINE;
        end else if (reg_wr_i && reg_addr_i == `OFS_FINE) begin
            fine_r <= reg_wdata_i;
        end
    end

    // ----------------------------------------
    // Divider phase status
    // ----------------------------------------
    always_comb begin
        phase_nxt = '0;
        if (align_en_i) begin
            if (neg_skew_i == 2'h0 && pos_skew_i == 2'h0) begin
                phase_nxt = phase_offset_i;
            end else begin
                phase_nxt = captured_phase_i;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            phase_r <= 4'h0;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    always_comb begin
        case (reg_addr_i)
            `OFS_PHASE_STATUS: rdata_nxt = {4'h0, phase_r};
            `OFS_DELAY_MODE:   rdata_nxt = {5'h00, mode_r};
            `OFS_SUPER_FINE:   rdata_nxt = super_fine_r;
            `OFS_FINE:         rdata_nxt = fine_r;
            default:           rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_nxt;
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // ----------------------------------------
    // Applied delay control
    // ----------------------------------------
    delay_limit u_limit (
        .mode_i       (mode_r),
        .fine_i       (fine_r),
        .super_fine_i (super_fine_r),
        .ctrl_o       (ctrl_nxt)
    );

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            delay_ctrl_o <= '0;
        end else begin
            delay_ctrl_o <= ctrl_nxt;
        end
    end
endmodule

// File: dv/sample_clock_delay_regs_assertions.sv
// Port checks for the delay register bank
// Assumes a bind onto sample_clock_delay_regs, one clock
module sample_clock_delay_regs_chk
    import clk_delay_pkg::*;
(
    // Clock, reset, register port
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic        reg_wr_i,
    input wire logic        reg_rd_i,
    input wire logic [7:0]  reg_rdata_o,
    // Phase sources, applied control
    input wire logic        align_en_i,
    input wire logic [1:0]  neg_skew_i,
    input wire logic [1:0]  pos_skew_i,
    input wire logic [3:0]  captured_phase_i,
    input wire logic [3:0]  phase_offset_i,
    input delay_ctrl_type   delay_ctrl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_ph_rd;
        reg_rd_i && reg_addr_i == 12'h010B && $stable({align_en_i,
            neg_skew_i, pos_skew_i, phase_offset_i, captured_phase_i});
    endsequence
    sequence s_quiet;
        !reg_wr_i ##1 !reg_wr_i;
    endsequence
    a_phase_off: assert property (s_ph_rd ##0 !align_en_i
        |=> reg_rdata_o == 8'h00) else $error("phase not zero");
    a_phase_match: assert property (s_ph_rd ##0 align_en_i
        && {neg_skew_i, pos_skew_i} == 4'h0
        |=> reg_rdata_o == {4'h0, $past(phase_offset_i)})
        else $error("phase not offset");
    a_phase_capt: assert property (s_ph_rd ##0 align_en_i
        && {neg_skew_i, pos_skew_i} != 4'h0
        |=> reg_rdata_o == {4'h0, $past(captured_phase_i)})
        else $error("phase not captured");
    a_mode_resv: assert property (reg_rd_i && reg_addr_i == 12'h0110
        |=> reg_rdata_o[7:3] == 5'h00) else $error("reserved bits set");
    a_fine_gate: assert property (!delay_ctrl_o.fine_en |->
        delay_ctrl_o.fine_steps == 8'h00 && !delay_ctrl_o.low_jitter)
        else $error("fine not gated");
    a_super_gate: assert property (!delay_ctrl_o.super_fine_en |->
        delay_ctrl_o.super_fine_steps == 8'h00) else $error("super open");
    a_lj_clamp: assert property (delay_ctrl_o.low_jitter |->
        delay_ctrl_o.fine_en && !delay_ctrl_o.super_fine_en
        && delay_ctrl_o.fine_steps <= 8'h10) else $error("low jitter bad");
    a_range_cap: assert property (delay_ctrl_o.fine_steps <= 8'hC0
        && delay_ctrl_o.super_fine_steps <= 8'h80) else $error("no clamp");
    a_ctrl_hold: assert property (s_quiet |=> $stable(delay_ctrl_o))
        else $error("control moved without write");
endmodule

// File: dv/sample_clock_delay_regs_tb.sv
// Self-checking bench for the delay register bank
// Assumes package, design and checker compiled first
module sample_clock_delay_regs_tb_top import clk_delay_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i, rst_i, reg_wr_i, reg_rd_i, align_en_i;
    logic [11:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o;
    logic [1:0] neg_skew_i, pos_skew_i;
    logic [3:0] captured_phase_i, phase_offset_i;
    delay_ctrl_type delay_ctrl_o;
    int err_total, n_compared;
    sample_clock_delay_regs dut (.sys_clk_i, .rst_i, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .align_en_i,
        .neg_skew_i, .pos_skew_i, .captured_phase_i, .phase_offset_i,
        .delay_ctrl_o);
    function automatic delay_ctrl_type ex(logic [2:0] m, logic [7:0] f, s);
        logic fe, se;
        logic [7:0] fm;
        fe = m inside {3'h2, 3'h3, 3'h4, 3'h6};
        se = m inside {3'h2, 3'h6};
        fm = (m == 3'h6) ? 8'hC0 : 8'h10;
        ex = '{fe, m inside {3'h3, 3'h4}, se, fe ? (f > fm ? fm : f) : 8'h00,
            se ? (s > 8'h80 ? 8'h80 : s) : 8'h00};
    endfunction
    task automatic chk_reg(string w, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %h got %h", w, e, g);
        end
    endtask
    task automatic ctl(delay_ctrl_type e);
        repeat (3) @(posedge sys_clk_i);
        #1;
        n_compared++;
        if (delay_ctrl_o !== e) begin
            err_total++;
            $display("wrong value ctrl exp %h got %h", e, delay_ctrl_o);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(logic [11:0] a, logic [7:0] e);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk_reg("rdata", e, reg_rdata_o);
    endtask
    task automatic ph(logic al, logic [1:0] ng, ps, logic [7:0] e);
        @(posedge sys_clk_i);
        align_en_i <= al;
        {neg_skew_i, pos_skew_i} <= {ng, ps};
        rd(12'h010B, e);
    endtask
    task automatic results;
        $display("compared %0d wrong %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        repeat (3000) @(posedge sys_clk_i);
        err_total++;
        results;
    end
    initial begin
        {rst_i, reg_wr_i, reg_rd_i, align_en_i} = 4'h8;
        {reg_addr_i, reg_wdata_i, neg_skew_i, pos_skew_i} = '0;
        {captured_phase_i, phase_offset_i} = 8'h59;
        repeat (6) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rd(12'h0110, 8'h00);
        rd(12'h0111, 8'h00);
        rd(12'h0112, 8'hC0);
        ctl('0);
        wr(12'h0110, 8'hFF);
        rd(12'h0110, 8'h07);
        wr(12'h0113, 8'h55);
        rd(12'h0113, 8'h00);
        $display("test reset and access done");
        wr(12'h0112, 8'hB4);
        rd(12'h0112, 8'hB4);
        wr(12'h0111, 8'h90);
        for (int m = 0; m < 8; m++) begin
            wr(12'h0110, 8'(m));
            ctl(ex(3'(m), 8'hB4, 8'h90));
        end
        rd(12'h0112, 8'hB4);
        wr(12'h0111, 8'h80);
        wr(12'h0112, 8'h10);
        ctl(ex(3'h7, 8'h10, 8'h80));
        wr(12'h0110, 8'h02);
        ctl(ex(3'h2, 8'h10, 8'h80));
        $display("test delay modes done");
        ph(1'b0, 2'h0, 2'h0, 8'h00);
        ph(1'b1, 2'h0, 2'h0, 8'h09);
        ph(1'b1, 2'h1, 2'h0, 8'h05);
        ph(1'b1, 2'h0, 2'h3, 8'h05);
        $display("test phase status done");
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        ctl('0);
        rd(12'h0112, 8'hC0);
        rd(12'h0111, 8'h00);
        $display("test mid-run reset done");
        results;
    end
endmodule
bind sample_clock_delay_regs sample_clock_delay_regs_chk u_chk (.sys_clk_i,
    .rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .align_en_i,
    .neg_skew_i, .pos_skew_i, .captured_phase_i, .phase_offset_i,
    .delay_ctrl_o);
